// File: pmu_mode_switch_sequencer.v
// Channel control register bank and measurement unit mode decode
//
// Overview of operation
// - Enable register resets to zero
// - Channel state register resets to zero
// - Unit state register resets to zero
// - Measure enable resets, output tristated
// - Differential comparator enable resets to zero
// - Overvoltage alarm mask resets to zero
// - Unit disabled when enable bit two clear
`timescale 1ns/100ps
module pmu_mode_switch_sequencer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Decoded register write from the serial port
  input  wire        wrStrobe,
  input  wire [4:0]  wrAddr,
  input  wire [15:0] wrData,
  // Register readback
  input  wire [4:0]  rdAddr,
  output reg  [15:0] rdData_q,
  // Measurement unit controls
  output reg         unitEnable_q,
  output reg         forceCurrent_q,
  output reg  [2:0]  currentRange_q,
  output reg  [1:0]  inputSource_q,
  output reg  [15:0] levelValue_q,
  // Pin and channel controls
  output reg         pinDriverPathOff_q,
  output reg         terminationDrive_q,
  output reg         highVoltageMode_q,
  output reg         activeLoad_q,
  output reg         measureOutEnable_q,
  output reg         diffCompEnable_q,
  output reg  [15:0] alarmMask_q
);
`include "pmu_consts.vh"

  // ==========================================================
  // Address match, shared by the write and read paths
  function addrMatch;
    input [4:0] addr;
    input [4:0] slot;
    begin
      addrMatch = (addr == slot);
    end
  endfunction

  // ==========================================================
  // Register storage
  localparam NREG = 7;

  wire [4:0] regAddr [0:NREG-1];
  wire [15:0] regVal [0:NREG-1];
  assign regAddr[0] = `ADDR_LEVEL;
  assign regAddr[1] = `ADDR_ENABLE;
  assign regAddr[2] = `ADDR_CHAN_STATE;
  assign regAddr[3] = `ADDR_UNIT_STATE;
  assign regAddr[4] = `ADDR_MEASURE_EN;
  assign regAddr[5] = `ADDR_DIFF_COMP;
  assign regAddr[6] = `ADDR_ALARM_MASK;

  genvar gi;

  // Write hits, one per register; unmapped addresses hit nothing
  wire [NREG-1:0] wrHit;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : gHits
      assign wrHit[gi] = wrStrobe & addrMatch(wrAddr, regAddr[gi]);
    end
  endgenerate

  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : gRegs
      reg_word uReg (
        .clk     (clk),
        .rst     (rst),
        .wrEn    (wrHit[gi]),
        .wrData  (wrData),
        .value_q (regVal[gi])
      );
    end
  endgenerate

  wire [15:0] enReg   = regVal[1];
  wire [15:0] chReg   = regVal[2];
  wire [15:0] stReg   = regVal[3];

  // ==========================================================
  // Input select decode
  function [1:0] decodeSource;
    input [1:0] sel;
    begin
      if (sel == `SEL_GROUND) begin
        decodeSource = `SRC_GROUND;
      end else if (sel == `SEL_OFFSET) begin
        decodeSource = `SRC_OFFSET;
      end else begin
        decodeSource = `SRC_LEVEL;
      end
    end
  endfunction

  // ==========================================================
  // Readback: unmapped addresses read zero
  reg [15:0] rdMux;
  integer k;
  always @* begin
    rdMux = `RST_WORD;
    for (k = 0; k < NREG; k = k + 1) begin
      if (addrMatch(rdAddr, regAddr[k])) begin
        rdMux = regVal[k];
      end
    end
  end

  // ==========================================================
  // Readback register
  // One cycle of latency keeps rdData_q straight off a flip-flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= `RST_WORD;
    end else begin
      rdData_q <= rdMux;
    end
  end

  // ==========================================================
  // Measurement unit controls
  // Ordering of host writes is trusted; outputs follow stored state
  // one cycle later, so a mid-sequence state appears briefly.
  // unit gated by enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unitEnable_q   <= 1'b0;
      forceCurrent_q <= 1'b0;
    end else begin
      unitEnable_q   <= enReg[`EN_UNIT_BIT];
      // A powered-down unit never reports force-current
      forceCurrent_q <= enReg[`EN_UNIT_BIT] & stReg[`ST_FORCE_I_BIT];
    end
  end

  // Range bits pass through even while disabled, so the range
  // can be set up before the unit is switched on
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      currentRange_q <= 3'h0;
    end else begin
      currentRange_q <= stReg[`ST_RANGE_HI:`ST_RANGE_LO];
    end
  end

  // ==========================================================
  // Force source and level
  // source select decode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inputSource_q <= `SRC_GROUND;
    end else begin
      inputSource_q <= decodeSource(stReg[`ST_SEL_HI:`ST_SEL_LO]);
    end
  end

  // Level word is forwarded whole on every cycle, whatever the source select holds
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      levelValue_q <= `RST_WORD;
    end else begin
      levelValue_q <= regVal[0];
    end
  end

  // ==========================================================
  // Pin driver and termination
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinDriverPathOff_q <= 1'b0;
      terminationDrive_q <= 1'b0;
    end else begin
      // Zero keeps the pin driver path enabled, as at reset
      pinDriverPathOff_q <= enReg[`EN_PINDRV_BIT];
      // Either the enable register or the channel state can terminate
      terminationDrive_q <= enReg[`EN_TERM_BIT] | chReg[`CH_TERM_BIT];
    end
  end

  // ==========================================================
  // Channel state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      highVoltageMode_q <= 1'b0;
      activeLoad_q      <= 1'b0;
    end else begin
      highVoltageMode_q <= chReg[`CH_HV_BIT];
      activeLoad_q      <= chReg[`CH_LOAD_BIT];
    end
  end

  // ==========================================================
  // Measure output, comparator mode and alarm mask
  // Any set bit enables, so unused bits cannot leave a half state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      measureOutEnable_q <= 1'b0;
      diffCompEnable_q   <= 1'b0;
      alarmMask_q        <= `RST_WORD;
    end else begin
      measureOutEnable_q <= |regVal[4];
      diffCompEnable_q   <= |regVal[5];
      alarmMask_q        <= regVal[6];
    end
  end

endmodule

// File: pmu_consts.vh
// Constants for the measurement unit control register bank
`ifndef PMU_MODE_SWITCH_CONSTS_VH
`define PMU_MODE_SWITCH_CONSTS_VH
// Register addresses on the 5-bit serial address
`define ADDR_LEVEL        5'h0b
`define ADDR_ENABLE       5'h0c
`define ADDR_CHAN_STATE   5'h0d
`define ADDR_UNIT_STATE   5'h0e
`define ADDR_MEASURE_EN   5'h0f
`define ADDR_DIFF_COMP    5'h10
`define ADDR_ALARM_MASK   5'h11
// Reset values
`define RST_WORD          16'h0000
// Field positions
`define EN_UNIT_BIT       2
`define EN_TERM_BIT       1
`define EN_PINDRV_BIT     0
`define ST_SEL_HI         9
`define ST_SEL_LO         8
`define ST_FORCE_I_BIT    3
`define ST_RANGE_HI       2
`define ST_RANGE_LO       0
`define CH_HV_BIT         2
`define CH_LOAD_BIT       1
`define CH_TERM_BIT       0
// Input select codes
`define SEL_GROUND        2'h0
`define SEL_OFFSET        2'h1
`define SRC_GROUND        2'h0
`define SRC_OFFSET        2'h1
`define SRC_LEVEL         2'h2
`endif

// File: reg_word.v
// One 16-bit control register with write enable and reset default
`timescale 1ns/100ps
module reg_word (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Write port
  input  wire        wrEn,
  input  wire [15:0] wrData,
  // Stored value
  output reg  [15:0] value_q
);
`include "pmu_consts.vh"

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= `RST_WORD;
    end else if (wrEn) begin
      value_q <= wrData;
    end
  end

endmodule

// File: pmu_checker.sv
// Assertions on the register bank ports
`timescale 1ns/100ps
module pmu_checker (
  // Write side and controls
  input logic clk, rst, wrStrobe, unitEnable_q, forceCurrent_q, pinDriverPathOff_q,
  input logic terminationDrive_q, highVoltageMode_q, activeLoad_q,
  input logic measureOutEnable_q, diffCompEnable_q,
  input logic [1:0] inputSource_q,
  input logic [2:0] currentRange_q,
  input logic [4:0] wrAddr,
  input logic [15:0] wrData, alarmMask_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr(a); wrStrobe && wrAddr == a; endsequence
  en_reset_a:
    assert property ($fell(rst) |-> !(unitEnable_q | pinDriverPathOff_q | terminationDrive_q))
    else $error("enable reset");
  chan_reset_a: assert property ($fell(rst) |-> !(highVoltageMode_q | activeLoad_q))
    else $error("channel reset");
  unit_reset_a:
    assert property ($fell(rst) |-> {forceCurrent_q, currentRange_q, inputSource_q} == 0)
    else $error("unit reset");
  meas_reset_a: assert property ($fell(rst) |-> !measureOutEnable_q)
    else $error("measure reset");
  diff_reset_a: assert property ($fell(rst) |-> !diffCompEnable_q)
    else $error("comparator reset");
  mask_reset_a: assert property ($fell(rst) |-> alarmMask_q == 0)
    else $error("mask reset");
  unit_enable_a: assert property (wr(5'h0c) |-> ##2 unitEnable_q == $past(wrData[2], 2))
    else $error("enable bit");
  source_decode_a:
    assert property (wr(5'h0e) |-> ##2 inputSource_q ==
      ($past(wrData[9], 2) ? 2'h2 : {1'b0, $past(wrData[8], 2)}))
    else $error("source decode");
endmodule
bind pmu_mode_switch_sequencer pmu_checker u_pmu_checker (.*);

// File: host_model.sv
// Host controller model issuing register writes
`timescale 1ns/100ps
module host_model (
  // Write port
  input wire clk,
  output logic wrStrobe,
  output logic [4:0] wrAddr,
  output logic [15:0] wrData
);
  initial {wrStrobe, wrAddr, wrData} = 0;
  // Data inverted between writes so a stale word never looks valid
  task wr(input [4:0] a, input [15:0] d);
    @(negedge clk) {wrStrobe, wrAddr, wrData} = {1'b1, a, d};
    @(negedge clk) {wrStrobe, wrData} = {1'b0, ~d};
  endtask
  task enable(input [2:0] r);
    wr(5'h0e, {13'h0, r});
    wr(5'h0c, 16'h0004);
  endtask
  task to_fi(input [15:0] v, input [2:0] r);
    wr(5'h0e, {13'h21, r});
    wr(5'h0b, v);
    wr(5'h0e, {13'h61, r});
  endtask
  task to_fv(input [15:0] v);
    wr(5'h0e, 16'h0);
    wr(5'h0b, v);
    wr(5'h0e, 16'h0200);
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst = 1, wrStrobe, unitEnable_q, forceCurrent_q, pinDriverPathOff_q;
  logic terminationDrive_q, highVoltageMode_q, activeLoad_q, measureOutEnable_q, diffCompEnable_q;
  logic [1:0] inputSource_q;
  logic [2:0] currentRange_q;
  logic [4:0] wrAddr, rdAddr = 0;
  logic [15:0] wrData, rdData_q, levelValue_q, alarmMask_q;
  int n_mismatch = 0, total_checks = 0;
  pmu_mode_switch_sequencer u_pmu_mode_switch_sequencer (.*);
  host_model u_host_model (.*);
  initial forever #2 clk = ~clk;
  task ck(input [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task rd(input [4:0] a, input [15:0] e);
    @(negedge clk) rdAddr = a;
    @(negedge clk) ck(rdData_q, e);
  endtask
  task t_reset;
    for (int a = 11; a < 18; a++) rd(a[4:0], 0);
  endtask
  task t_fi;
    u_host_model.enable(3'h5);
    @(negedge clk) ck({forceCurrent_q, unitEnable_q}, 1);
    u_host_model.to_fi(16'hbeef, 3'h3);
    @(negedge clk) ck({forceCurrent_q, currentRange_q, inputSource_q}, 16'h2e);
    ck(levelValue_q, 16'hbeef);
  endtask
  task t_fv;
    u_host_model.to_fv(16'h1234);
    @(negedge clk) ck({forceCurrent_q, currentRange_q, inputSource_q}, 16'h02);
    rd(5'h0e, 16'h0200);
  endtask
  task t_misc;
    u_host_model.wr(5'h1f, 16'hffff);
    u_host_model.wr(5'h0d, 16'h0006);
    u_host_model.wr(5'h0c, 16'h0003);
    @(negedge clk) ck({pinDriverPathOff_q, terminationDrive_q, highVoltageMode_q,
      activeLoad_q, unitEnable_q}, 16'h1e);
    rd(5'h1f, 0);
    u_host_model.wr(5'h0e, 16'h0108);
    u_host_model.wr(5'h0f, 16'h0010);
    u_host_model.wr(5'h10, 16'h8000);
    u_host_model.wr(5'h11, 16'ha5a5);
    @(negedge clk) ck({forceCurrent_q, inputSource_q}, 16'h1);
    ck({measureOutEnable_q, diffCompEnable_q}, 16'h3);
    ck(alarmMask_q, 16'ha5a5);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    t_reset;
    t_fi;
    t_fv;
    t_misc;
    print_verdict;
  end
  initial begin
    #100000 n_mismatch++;
    print_verdict;
  end
endmodule
